// ---- core/sai_cfg.svh ----
// constants and register layout for the six-channel audio serial link
//
// Contract
// - system clock is 128..768 times sample rate
// - buffered clock out at full or half rate
// - buffered clock enable bit, enabled after reset
// - power-on runs 1024-clock init, then defaults
// - external reset held low at least 20ns
// - reset rise starts 1024-clock init, then defaults
// - hold reset low until system clock runs
// - data lines sampled on bit clock rising edge
// - word clock at sample rate moves words
// - bit and word clocks synchronous to system clock
// - bit clock is 48 or 64 times rate
// - standard, i2s, left-justified via three-bit field
// - reset format is 24-bit standard
// - two's complement, most significant bit first
// - left word always precedes right word
// - lines a,b,c feed channels 1-2,3-4,5-6
// - at 192kHz disable channels 3 to 6
`ifndef SAI_CFG_SVH
`define SAI_CFG_SVH

`define SAI_SAMPLE_W 24
`define SAI_CHANS 6
`define SAI_LINES 3
`define SAI_INIT_CYCLES 1024
`define SAI_CLK_NS 10
`define SAI_EXT_RST_MIN_NS 20
`define SAI_EXT_RST_CYC ((`SAI_EXT_RST_MIN_NS + `SAI_CLK_NS - 1) / `SAI_CLK_NS)
`define SAI_SLOTS_48 5'h18
`define SAI_SLOTS_64 5'h20
`define SAI_BITS_24 5'h18
`define SAI_BITS_20 5'h14
`define SAI_BITS_18 5'h12
`define SAI_BITS_16 5'h10

// device registers: index, byte address is four times the index
`define SAI_DEV_CHAN_IDX 6'h08
`define SAI_DEV_FMT_IDX 6'h09
`define SAI_DEV_STAT_IDX 6'h0c
`define SAI_DEV_CHAN_RST 6'h00
`define SAI_DEV_FMT_POS 0
`define SAI_DEV_HALF_POS 3
`define SAI_DEV_CKEN_POS 4
`define SAI_DEV_STAT_BUSY_POS 0
`define SAI_DEV_STAT_WCLK_POS 1
`define SAI_DEV_STAT_CNT_POS 8

// source-end registers, byte addresses
`define SAI_HOST_CTRL_OFS 8'h00
`define SAI_HOST_DIV_OFS 8'h04
`define SAI_HOST_STAT_OFS 8'h08
`define SAI_HOST_SMP_OFS 8'h10
`define SAI_HOST_RUN_POS 0
`define SAI_HOST_B48_POS 1
`define SAI_HOST_FMT_POS 2
`define SAI_HOST_RST_POS 5
`define SAI_HOST_DIV_RST 8'h04

`endif

// ---- core/sai_pkg.sv ----
// shared types and format helpers for the audio serial link
`include "sai_cfg.svh"

package sai_pkg;

    // serial format codes held in the format field
    typedef enum logic [2:0] {
        sai_fmt_std24 = 3'b000,
        sai_fmt_std20 = 3'b001,
        sai_fmt_std18 = 3'b010,
        sai_fmt_std16 = 3'b011,
        sai_fmt_i2s = 3'b100,
        sai_fmt_lj = 3'b101
    } sai_fmt_t;

    typedef enum logic [0:0] {
        sai_st_run = 1'b0,
        sai_st_init = 1'b1
    } sai_init_st_t;

    typedef logic [`SAI_SAMPLE_W-1:0] sai_sample_t;

    // unknown codes fall back to the 24-bit standard width
    function automatic logic [4:0] sai_word_bits(input sai_fmt_t f);
        case (f)
            sai_fmt_std20: sai_word_bits = `SAI_BITS_20;
            sai_fmt_std18: sai_word_bits = `SAI_BITS_18;
            sai_fmt_std16: sai_word_bits = `SAI_BITS_16;
            default: sai_word_bits = `SAI_BITS_24;
        endcase
    endfunction

    function automatic logic sai_is_rj(input sai_fmt_t f);
        sai_is_rj = (f != sai_fmt_i2s) && (f != sai_fmt_lj);
    endfunction

endpackage

// ---- core/sai_if.sv ----
// link between the audio source and the receiving device
`timescale 1ns/10ps
`default_nettype none

interface sai_if;
    logic audio_bit_clk;
    logic audio_word_clk;
    logic serial_in_a;
    logic serial_in_b;
    logic serial_in_c;
    logic ext_rst_n;
    logic buffered_clk_out;

    modport dev (
        input audio_bit_clk, audio_word_clk, serial_in_a, serial_in_b, serial_in_c,
        input ext_rst_n,
        output buffered_clk_out
    );

    modport src (
        output audio_bit_clk, audio_word_clk, serial_in_a, serial_in_b, serial_in_c,
        output ext_rst_n,
        input buffered_clk_out
    );
endinterface

`default_nettype wire

// ---- core/sai_rx.sv ----
// one serial data line: shifts bits and releases left and right words
`timescale 1ns/10ps
`default_nettype none
`include "sai_cfg.svh"

module sai_rx (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    // link strobes
    input wire logic bit_rise,
    input wire logic word_lvl,
    input wire logic din,
    input wire sai_pkg::sai_fmt_t fmt,
    // words out
    output logic [`SAI_SAMPLE_W-1:0] left_o,
    output logic [`SAI_SAMPLE_W-1:0] right_o,
    output logic pair_done
);
    import sai_pkg::*;

    logic word_prev_r;
    logic [4:0] cnt_r;
    logic [`SAI_SAMPLE_W-1:0] sr_all_r;
    logic [`SAI_SAMPLE_W-1:0] sr_first_r;

    // a word-clock change seen at a bit-clock rise closes the half just shifted
    wire edge_seen = bit_rise && (word_lvl != word_prev_r);
    wire is_i2s = (fmt == sai_fmt_i2s);
    wire is_lj = (fmt == sai_fmt_lj);
    wire [4:0] slot = edge_seen ? 5'h00 : cnt_r;
    // i2s holds back one bit clock after the word-clock edge
    wire in_win = is_lj ? (slot < `SAI_BITS_24) : (slot >= 5'h01 && slot <= `SAI_BITS_24);
    wire ended_left = is_i2s ? !word_prev_r : word_prev_r;
    wire [4:0] nbits = sai_word_bits(fmt);
    wire [`SAI_SAMPLE_W-1:0] rj_mask = ~(`SAI_SAMPLE_W'('1) << nbits);
    wire rj_sign = sr_all_r[nbits - 5'h01];
    // right-justified words are the last n bits before the edge, sign-extended
    wire [`SAI_SAMPLE_W-1:0] rj_word = (sr_all_r & rj_mask) | (rj_sign ? ~rj_mask : '0);
    wire [`SAI_SAMPLE_W-1:0] word_done = sai_is_rj(fmt) ? rj_word : sr_first_r;
    wire [`SAI_SAMPLE_W-1:0] first_base = edge_seen ? '0 : sr_first_r;
    wire [`SAI_SAMPLE_W-1:0] sr_first_nxt = in_win ? {first_base[`SAI_SAMPLE_W-2:0], din}
                                                   : first_base;

    // shift on every bit-clock rise, msb first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_prev_r <= 1'b0;
            cnt_r <= 5'h00;
            sr_all_r <= '0;
            sr_first_r <= '0;
        end else if (clear) begin
            word_prev_r <= 1'b0;
            cnt_r <= 5'h00;
            sr_all_r <= '0;
            sr_first_r <= '0;
        end else if (bit_rise) begin
            word_prev_r <= word_lvl;
            cnt_r <= (slot == 5'h1f) ? slot : slot + 5'h01;
            sr_all_r <= {sr_all_r[`SAI_SAMPLE_W-2:0], din};
            sr_first_r <= sr_first_nxt;
        end
    end

    // word clock moves the finished word out; right closes the pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_o <= '0;
            right_o <= '0;
            pair_done <= 1'b0;
        end else begin
            pair_done <= !clear && edge_seen && !ended_left;
            if (!clear && edge_seen && ended_left) begin
                left_o <= word_done;
            end
            if (!clear && edge_seen && !ended_left) begin
                right_o <= word_done;
            end
        end
    end
endmodule

`default_nettype wire

// ---- core/sai_dev.sv ----
// receiving device end: init sequencing, clock buffer, three-line receiver
`timescale 1ns/10ps
`default_nettype none
`include "sai_cfg.svh"

module sai_dev #(
    parameter int INIT_CYCLES = `SAI_INIT_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // samples to downstream filtering
    output logic [`SAI_CHANS*`SAI_SAMPLE_W-1:0] chan_samples,
    output logic sample_valid,
    // audio link
    sai_if.dev link
);
    import sai_pkg::*;

    // init sequencing; the counter covers the full count, end point included
    localparam int INIT_W = $clog2(INIT_CYCLES + 1);
    sai_init_st_t st_r;
    logic [INIT_W-1:0] init_cnt_r;
    logic ext_rst_prev_r;

    // mode settings
    logic [5:0] chan_off_r;
    sai_fmt_t format_select_r;
    logic clk_out_half_rate_r;
    logic clk_out_enable_r;

    // clock buffer, link edge and frame count
    logic div_r;
    logic bck_prev_r;
    logic [7:0] frames_r;

    // apb answer and samples out
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [`SAI_CHANS*`SAI_SAMPLE_W-1:0] samples_r;
    logic valid_r;

    // word-aligned register hit; byte lanes below bit 2 are ignored
    function automatic logic reg_hit(input logic [7:0] a, input logic [5:0] idx);
        reg_hit = (a[7:2] == idx);
    endfunction

    // apb decode
    wire setup = psel && !penable;
    // writes while busy are dropped without an error, as the defaults win
    wire wr_take = psel && penable && pready_r && pwrite;
    wire sel_chan = reg_hit(paddr, `SAI_DEV_CHAN_IDX);
    wire sel_fmt = reg_hit(paddr, `SAI_DEV_FMT_IDX);
    wire sel_stat = reg_hit(paddr, `SAI_DEV_STAT_IDX);
    wire mapped = sel_chan || sel_fmt || sel_stat;
    wire busy = (st_r == sai_st_init);
    wire [31:0] rd_chan = {26'h0, chan_off_r};
    wire [31:0] rd_fmt = {27'h0, clk_out_enable_r, clk_out_half_rate_r, format_select_r};
    wire [31:0] rd_stat = {16'h0, frames_r, 6'h0, link.audio_word_clk, busy};
    wire [31:0] rd_mux = sel_chan ? rd_chan : sel_fmt ? rd_fmt : sel_stat ? rd_stat : 32'h0;

    // init runs after power-on and after each rise of the external reset
    wire ext_rise = link.ext_rst_n && !ext_rst_prev_r;
    wire init_last = (init_cnt_r == INIT_W'(INIT_CYCLES - 1));

    // prev starts low, so the first rise after power-on restarts init: harmless
    // the count sits at zero while the pin is low, so a long low adds no time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= sai_st_init;
            init_cnt_r <= '0;
            ext_rst_prev_r <= 1'b0;
        end else begin
            ext_rst_prev_r <= link.ext_rst_n;
            if (!link.ext_rst_n || ext_rise) begin
                st_r <= sai_st_init;
                init_cnt_r <= '0;
            end else if (busy) begin
                init_cnt_r <= init_cnt_r + INIT_W'(1);
                st_r <= init_last ? sai_st_run : sai_st_init;
            end
        end
    end

    // mode settings: defaults restored from the first cycle of every init
    // forced for the whole init, so a write racing the init cannot stick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_off_r <= `SAI_DEV_CHAN_RST;
            format_select_r <= sai_fmt_std24;
            clk_out_half_rate_r <= 1'b0;
            clk_out_enable_r <= 1'b1;
        end else if (busy) begin
            chan_off_r <= `SAI_DEV_CHAN_RST;
            format_select_r <= sai_fmt_std24;
            clk_out_half_rate_r <= 1'b0;
            clk_out_enable_r <= 1'b1;
        end else if (wr_take && sel_chan) begin
            chan_off_r <= pwdata[5:0];
        end else if (wr_take && sel_fmt) begin
            format_select_r <= sai_fmt_t'(pwdata[`SAI_DEV_FMT_POS +: 3]);
            clk_out_half_rate_r <= pwdata[`SAI_DEV_HALF_POS];
            clk_out_enable_r <= pwdata[`SAI_DEV_CKEN_POS];
        end
    end

    // apb answer: one access cycle, unmapped addresses flag an error
    // prdata is loaded at setup and holds until the next setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && !mapped;
            if (setup) begin
                prdata_r <= rd_mux;
            end
        end
    end

    // buffered clock: the full rate path is a gated copy, not a flop,
    // since no flop can toggle at its own clock rate
    // changing the enable while pclk is high can clip one pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 1'b0;
        end else begin
            div_r <= !div_r;
        end
    end
    assign link.buffered_clk_out = clk_out_enable_r
                                 & (clk_out_half_rate_r ? div_r : pclk);

    // the link is synchronous to pclk, so a plain edge detect suffices
    wire bit_rise = link.audio_bit_clk && !bck_prev_r;
    wire [`SAI_LINES-1:0] din = {link.serial_in_c, link.serial_in_b, link.serial_in_a};
    wire [`SAI_LINES-1:0] pair_done;
    wire [`SAI_LINES*2*`SAI_SAMPLE_W-1:0] words;

    // line k feeds channels 2k+1 (left) and 2k+2 (right)
    // all lines share one edge detect, so the three receivers stay in step
    genvar k;
    generate
        for (k = 0; k < `SAI_LINES; k++) begin : g_line
            sai_rx u_rx (
                .pclk(pclk),
                .presetn(presetn),
                .clear(busy),
                .bit_rise(bit_rise),
                .word_lvl(link.audio_word_clk),
                .din(din[k]),
                .fmt(format_select_r),
                .left_o(words[(2*k)*`SAI_SAMPLE_W +: `SAI_SAMPLE_W]),
                .right_o(words[(2*k+1)*`SAI_SAMPLE_W +: `SAI_SAMPLE_W]),
                .pair_done(pair_done[k])
            );
        end
    endgenerate

    // disabled channels present zero
    logic [`SAI_CHANS*`SAI_SAMPLE_W-1:0] gated;
    always_comb begin
        gated = words;
        for (int c = 0; c < `SAI_CHANS; c++) begin
            if (chan_off_r[c]) begin
                gated[c*`SAI_SAMPLE_W +: `SAI_SAMPLE_W] = '0;
            end
        end
    end

    // all lines share the clocks, so line a's pair marks the frame
    // the frame count wraps at 256; software should read differences
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bck_prev_r <= 1'b0;
            samples_r <= '0;
            valid_r <= 1'b0;
            frames_r <= 8'h00;
        end else begin
            bck_prev_r <= link.audio_bit_clk;
            valid_r <= pair_done[0];
            if (pair_done[0]) begin
                samples_r <= gated;
                frames_r <= frames_r + 8'h01;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign chan_samples = samples_r;
    assign sample_valid = valid_r;
endmodule

`default_nettype wire

// ---- core/sai_src.sv ----
// audio source end: derives the link clocks and serialises six samples
`timescale 1ns/10ps
`default_nettype none
`include "sai_cfg.svh"

module sai_src (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // audio link
    sai_if.src link
);
    import sai_pkg::*;

    logic run_r;
    logic b48_r;
    sai_fmt_t fmt_r;
    logic rst_req_r;
    logic [7:0] div_r;
    logic [`SAI_SAMPLE_W-1:0] smp_r [`SAI_CHANS];
    logic [15:0] frames_r;
    logic [1:0] rst_hold_r;
    logic ext_rst_n_r;
    logic [7:0] div_cnt_r;
    logic bck_r;
    logic audio_word_clk_r;
    logic [`SAI_LINES-1:0] data_r;
    logic [4:0] slot_r;
    logic half_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // apb decode
    wire setup = psel && !penable;
    wire wr_take = psel && penable && pready_r && pwrite;
    wire sel_ctrl = (paddr == `SAI_HOST_CTRL_OFS);
    wire sel_div = (paddr == `SAI_HOST_DIV_OFS);
    wire sel_stat = (paddr == `SAI_HOST_STAT_OFS);
    wire [7:0] smp_off = paddr - `SAI_HOST_SMP_OFS;
    wire [2:0] smp_idx = smp_off[4:2];
    wire sel_smp = (paddr >= `SAI_HOST_SMP_OFS) && (smp_off[1:0] == 2'b00)
                && (smp_off[7:2] < 6'(`SAI_CHANS));
    wire [31:0] rd_ctrl = {26'h0, rst_req_r, fmt_r, b48_r, run_r};
    wire [31:0] rd_mux = sel_ctrl ? rd_ctrl
                       : sel_div ? {24'h0, div_r}
                       : sel_stat ? {16'h0, frames_r}
                       : sel_smp ? {8'h0, smp_r[smp_idx]} : 32'h0;

    // control and sample registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 1'b0;
            b48_r <= 1'b0;
            fmt_r <= sai_fmt_std24;
            rst_req_r <= 1'b0;
            div_r <= `SAI_HOST_DIV_RST;
            for (int i = 0; i < `SAI_CHANS; i++) begin
                smp_r[i] <= '0;
            end
        end else if (wr_take) begin
            if (sel_ctrl) begin
                run_r <= pwdata[`SAI_HOST_RUN_POS];
                b48_r <= pwdata[`SAI_HOST_B48_POS];
                fmt_r <= sai_fmt_t'(pwdata[`SAI_HOST_FMT_POS +: 3]);
                rst_req_r <= pwdata[`SAI_HOST_RST_POS];
            end
            if (sel_div) begin
                div_r <= pwdata[7:0];
            end
            if (sel_smp) begin
                smp_r[smp_idx] <= pwdata[`SAI_SAMPLE_W-1:0];
            end
        end
    end

    // apb answer: one access cycle, unmapped addresses flag an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && !(sel_ctrl || sel_div || sel_stat || sel_smp);
            if (setup) begin
                prdata_r <= rd_mux;
            end
        end
    end

    // external reset: low while requested, and for at least a least time from the request
    wire rst_set = wr_take && sel_ctrl && pwdata[`SAI_HOST_RST_POS];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_hold_r <= 2'h0;
            ext_rst_n_r <= 1'b0;
        end else begin
            if (rst_set) begin
                rst_hold_r <= 2'(`SAI_EXT_RST_CYC);
            end else if (rst_hold_r != 2'h0) begin
                rst_hold_r <= rst_hold_r - 2'h1;
            end
            ext_rst_n_r <= !(rst_set || rst_req_r || rst_hold_r != 2'h0);
        end
    end

    // bit value for one slot: msb first, zero outside the word
    function automatic logic tx_bit(input logic [`SAI_SAMPLE_W-1:0] s, input sai_fmt_t f,
                                    input logic [4:0] slot, input logic [4:0] slots);
        logic [4:0] from_end;
        logic [4:0] n;
        from_end = slots - slot - 5'h01;
        n = sai_word_bits(f);
        if (sai_is_rj(f)) begin
            tx_bit = (from_end < n) ? s[from_end] : 1'b0;
        end else if (f == sai_fmt_lj) begin
            tx_bit = (slot < `SAI_BITS_24) ? s[`SAI_BITS_24 - slot - 5'h01] : 1'b0;
        end else begin
            tx_bit = (slot >= 5'h01 && slot <= `SAI_BITS_24) ? s[`SAI_BITS_24 - slot] : 1'b0;
        end
    endfunction

    // slot advance happens on the falling bit-clock edge so data is stable at the rise
    wire [4:0] slots = b48_r ? `SAI_SLOTS_48 : `SAI_SLOTS_64;
    // the reset divider of 4 gives 512 or 384 pclk per frame, both legal ratios
    wire tick = (div_cnt_r >= div_r - 8'h01) || (div_r == 8'h00);
    wire fall = run_r && tick && bck_r;
    wire slot_wrap = (slot_r == slots - 5'h01);
    wire [4:0] slot_nxt = !run_r ? 5'h00 : fall ? (slot_wrap ? 5'h00 : slot_r + 5'h01) : slot_r;
    wire half_nxt = !run_r ? 1'b0 : (fall && slot_wrap) ? !half_r : half_r;
    // left half (half 0) is high on the word clock except in i2s
    wire audio_word_clk_nxt = (fmt_r == sai_fmt_i2s) ? half_nxt : !half_nxt;
    logic [`SAI_LINES-1:0] data_nxt;
    always_comb begin
        data_nxt = '0;
        for (int k = 0; k < `SAI_LINES; k++) begin
            data_nxt[k] = tx_bit(smp_r[2*k + int'(half_nxt)], fmt_r, slot_nxt, slots);
        end
    end

    // bit and word clocks are divided down from pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 8'h00;
            bck_r <= 1'b0;
            slot_r <= 5'h00;
            half_r <= 1'b0;
            audio_word_clk_r <= 1'b0;
            data_r <= '0;
            frames_r <= 16'h0000;
        end else begin
            div_cnt_r <= (!run_r || tick) ? 8'h00 : div_cnt_r + 8'h01;
            bck_r <= run_r && (tick ? !bck_r : bck_r);
            slot_r <= slot_nxt;
            half_r <= half_nxt;
            // lines move only with the falling bit clock or while stopped, so a register write
            // mid-frame cannot disturb a bit that the device is about to sample
            if (!run_r || fall) begin
                audio_word_clk_r <= audio_word_clk_nxt;
                data_r <= data_nxt;
            end
            if (fall && slot_wrap && half_r) begin
                frames_r <= frames_r + 16'h0001;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign link.audio_bit_clk = bck_r;
    assign link.audio_word_clk = audio_word_clk_r;
    assign link.serial_in_a = data_r[0];
    assign link.serial_in_b = data_r[1];
    assign link.serial_in_c = data_r[2];
    assign link.ext_rst_n = ext_rst_n_r;
endmodule

`default_nettype wire

// ---- dv/sai_link_asserts.sv ----
// wire checks on the audio link between source and device
`timescale 1ns/10ps
`default_nettype none
module sai_link_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link wires
    input wire logic audio_bit_clk,
    input wire logic audio_word_clk,
    input wire logic serial_in_a,
    input wire logic serial_in_b,
    input wire logic serial_in_c,
    input wire logic ext_rst_n,
    input wire logic buffered_clk_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // bit clock already high, so a sampling rise has passed
    sequence s_bhi; audio_bit_clk && $past(audio_bit_clk); endsequence
    sequence s_hi2; audio_bit_clk [*2]; endsequence
    sequence s_lo2; !ext_rst_n [*2]; endsequence
    property p_dat_a; s_bhi |-> $stable(serial_in_a); endproperty
    property p_dat_b; s_bhi |-> $stable(serial_in_b); endproperty
    property p_dat_c; s_bhi |-> $stable(serial_in_c); endproperty
    property p_word_hold; s_bhi |-> $stable(audio_word_clk); endproperty
    property p_word_edge; $changed(audio_word_clk) |-> !audio_bit_clk; endproperty
    property p_bck_width; $rose(audio_bit_clk) |-> s_hi2; endproperty
    property p_rst_hold; $fell(ext_rst_n) |-> s_lo2; endproperty
    property p_rst_rel; $rose(presetn) |=> ext_rst_n; endproperty
    // seen at pclk rise: low at full rate, alternating at half rate
    property p_bco_half; buffered_clk_out |=> !buffered_clk_out; endproperty
    // lines hold steady while the bit clock stays high after the sampling rise
    a_dat_a: assert property (p_dat_a) else $error("line a moved");
    a_dat_b: assert property (p_dat_b) else $error("line b moved");
    a_dat_c: assert property (p_dat_c) else $error("line c moved");
    a_word_hold: assert property (p_word_hold) else $error("word clock moved");
    a_word_edge: assert property (p_word_edge) else $error("word edge off");
    a_bck_width: assert property (p_bck_width) else $error("short bit clock");
    a_rst_hold: assert property (p_rst_hold) else $error("reset too short");
    a_rst_rel: assert property (p_rst_rel) else $error("reset stuck low");
    a_bco_half: assert property (p_bco_half) else $error("buffered clock stuck");
endmodule
`default_nettype wire

// ---- dv/six_channel_audio_serial_input_test.sv ----
// bench joining the source and device ends of the audio link
`timescale 1ns/10ps
`default_nettype none
module six_channel_audio_serial_input_test;
    logic pclk = 0, presetn = 0, pen = 0, pwr = 0, sd = 0, ss = 0, er;
    logic [7:0] pa = 0;
    logic [31:0] pwd = 0, rd, rdd, rds;
    logic rdyd, rdys, erd, ers, sv;
    logic [143:0] cs, ex, gs;
    // {format, 48x} nibble, then the channel 1 sample
    logic [27:0] rows [8] = '{28'h0800000, 28'h2f80000, 28'h4fe0000, 28'h6ff8000,
        28'h87ffff0, 28'hb123456, 28'h1ab0000, 28'hc5a5a5a};
    logic [31:0] bm [3] = '{32'h10, 32'h18, 32'h00};
    int be [3] = '{20, 10, 0};
    int num_errors = 0, n_checks = 0, cyc = 0, bco = 0;
    sai_if lnk ();
    sai_dev #(.INIT_CYCLES(16)) sai_dev_i (.pclk(pclk), .presetn(presetn), .psel(sd),
        .penable(pen), .pwrite(pwr), .paddr(pa), .pwdata(pwd), .prdata(rdd), .pready(rdyd),
        .pslverr(erd), .chan_samples(cs), .sample_valid(sv), .link(lnk));
    sai_src sai_src_i (.pclk(pclk), .presetn(presetn), .psel(ss), .penable(pen),
        .pwrite(pwr), .paddr(pa), .pwdata(pwd), .prdata(rds), .pready(rdys),
        .pslverr(ers), .link(lnk));
    sai_link_asserts sai_link_asserts_i (.pclk(pclk), .presetn(presetn),
        .audio_bit_clk(lnk.audio_bit_clk), .audio_word_clk(lnk.audio_word_clk),
        .serial_in_a(lnk.serial_in_a), .serial_in_b(lnk.serial_in_b),
        .serial_in_c(lnk.serial_in_c), .ext_rst_n(lnk.ext_rst_n),
        .buffered_clk_out(lnk.buffered_clk_out));
    // free-running clock and buffered clock edge count
    always #5 pclk = ~pclk;
    always @(posedge lnk.buffered_clk_out) bco++;
    // hang guard, well above the longest run
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [143:0] got, input logic [143:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer; d picks the device end, else the source end
    task automatic ap(input logic d, input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        sd <= d;
        ss <= !d;
        pwr <= w;
        pa <= a;
        pwd <= wd;
        @(posedge pclk);
        pen <= 1;
        // no local limit: only the hang guard ends a wait
        do @(posedge pclk); while (!(d ? rdyd : rdys));
        rd = d ? rdd : rds;
        er = d ? erd : ers;
        sd <= 0;
        ss <= 0;
        pen <= 0;
    endtask
    // wait for a strobe, keep its samples, expect it gone next cycle
    task automatic wv();
        do @(posedge pclk); while (sv !== 1'b1);
        gs = cs;
        @(posedge pclk);
        chk(144'(sv), 144'h0);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        // writes during init are dropped
        ap(1, 1, 8'h24, 32'h0b);
        ap(1, 0, 8'h30, 0);
        chk(144'(rd[0]), 144'h1);
        repeat (30) @(posedge pclk);
        ap(1, 0, 8'h24, 0);
        chk(144'(rd), 144'h10);
        ap(1, 0, 8'h3c, 0);
        chk(144'({er, rd}), 144'h100000000);
        // source end: divider reset value, then an unmapped address
        ap(0, 0, 8'h04, 0);
        chk(144'({er, rd}), 144'h4);
        ap(0, 0, 8'h0c, 0);
        chk(144'({er, rd}), 144'h100000000);
        // every format code; live changes, so early frames are dropped
        foreach (rows[r]) begin
            ap(1, 1, 8'h24, {27'h0, 2'b10, rows[r][27:25]});
            for (int c = 0; c < 6; c++) begin
                ap(0, 1, 8'h10 + 8'(4 * c), {8'h0, rows[r][23:0] + 24'(c)});
                ex[c*24+:24] = rows[r][23:0] + 24'(c);
            end
            ap(0, 1, 8'h00, {27'h0, rows[r][27:24], 1'b1});
            repeat (3) wv();
            chk(gs, ex);
        end
        // channels 3 to 6 forced silent
        ap(1, 1, 8'h20, 32'h3c);
        ex[143:48] = 0;
        repeat (3) wv();
        chk(gs, ex);
        ap(1, 1, 8'h20, 0);
        // full, half, then no buffered clock
        for (int i = 0; i < 3; i++) begin
            ap(1, 1, 8'h24, bm[i]);
            @(negedge pclk);
            bco = 0;
            repeat (20) @(negedge pclk);
            chk(144'(bco), 144'(be[i]));
        end
        // external reset restores the defaults
        ap(1, 1, 8'h24, 32'h1d);
        ap(0, 1, 8'h00, 32'h21);
        ap(0, 1, 8'h00, 32'h01);
        ap(1, 0, 8'h30, 0);
        chk(144'(rd[0]), 144'h1);
        repeat (30) @(posedge pclk);
        ap(1, 0, 8'h24, 0);
        chk(144'(rd), 144'h10);
        print_verdict();
    end
endmodule
`default_nettype wire
